// *** verilog/dtm_timers.sv ***
// Purpose: timers 0/1 (modes 0-3) and timer 2 with capture/reload
// Assumes: pins synchronous to i_clk; one count per clock when timing
// Notes:   event pins count on falling edge seen between two clocks
module dtm_timers (
   input  wire logic         i_clk,
   input  wire logic         i_reset,
   input  dtm_pkg::dtm_sfr_s i_sfr,
   output logic [7:0]        o_rdata,
   input  wire logic         i_ext_irq0_input,
   input  wire logic         i_ext_irq1_input,
   input  wire logic         i_timer0_event_pin,
   input  wire logic         i_timer1_event_pin,
   input  wire logic         i_timer2_event_pin,
   input  wire logic         i_timer2_trigger_pin,
   output logic              o_timer0_irq,
   output logic              o_timer1_irq,
   output logic              o_timer2_irq,
   output logic              o_serial_rx_clk,
   output logic              o_serial_tx_clk
);
   logic [7:0] timer_control_reg_r, timer_mode_reg_r;
   logic [7:0] t0l_r, t0h_r, t1l_r, t1h_r;
   logic [7:0] t2ctl_r, t2rll_r, t2rlh_r, t2l_r, t2h_r;
   logic [4:0] pin_d_r;
   dtm_pkg::dtm_tmode_s m0, m1;
   logic       inc0, inc1, inc0h;
   logic       ovf0, ovf1, ovf0h, ovf2, trig;
   logic       t2_serial, wr;

   assign m0 = dtm_pkg::dtm_tmode_s'(timer_mode_reg_r[3:0]);
   assign m1 = dtm_pkg::dtm_tmode_s'(timer_mode_reg_r[7:4]);
   assign wr = i_sfr.wr;

   // falling edge when the previous sample was high and current is low
   function automatic logic fall(input logic prev, input logic cur);
      return prev & ~cur;
   endfunction

   // count enable shared by timers 0 and 1
   function automatic logic cnt_en(input logic run, input logic gate, input logic irq,
                                   input logic ct, input logic prev, input logic cur);
      return run & (~gate | irq) & (~ct | fall(prev, cur));
   endfunction

   // pin history for edge detection
   always_ff @(posedge i_clk or posedge i_reset) begin
      if (i_reset) begin
         pin_d_r <= 5'h00;
      end else begin
         pin_d_r <= {i_timer2_trigger_pin, i_timer2_event_pin, i_timer1_event_pin,
                     i_timer0_event_pin, 1'b0};
      end
   end

   assign inc0  = cnt_en(timer_control_reg_r[dtm_pkg::B_TR0], m0.gate, i_ext_irq0_input, m0.ct,
                         pin_d_r[1], i_timer0_event_pin);
   // timer 1 frozen in its own split mode
   assign inc1  = (m1.mode != dtm_pkg::DTM_MSPLT)
                  & cnt_en(timer_control_reg_r[dtm_pkg::B_TR1], m1.gate, i_ext_irq1_input, m1.ct,
                           pin_d_r[2], i_timer1_event_pin);
   // split mode high byte: machine cycles only, gated by timer 1 run
   assign inc0h = (m0.mode == dtm_pkg::DTM_MSPLT) & timer_control_reg_r[dtm_pkg::B_TR1];

   // timer 0: counting per mode; sfr writes take priority over counting
   always_ff @(posedge i_clk or posedge i_reset) begin
      if (i_reset) begin
         t0l_r <= dtm_pkg::RST_BYTE;
         t0h_r <= dtm_pkg::RST_BYTE;
      end else begin
         if (wr && i_sfr.addr == dtm_pkg::ADR_T0L) begin
            t0l_r <= i_sfr.wdata;
         end else if (inc0) begin
            unique case (m0.mode)
               dtm_pkg::DTM_M13: t0l_r <= {3'h0, t0l_r[4:0] + 5'h01};
               dtm_pkg::DTM_M16: t0l_r <= t0l_r + 8'h01;
               dtm_pkg::DTM_MRLD: t0l_r <= (t0l_r == 8'hff) ? t0h_r : t0l_r + 8'h01;
               dtm_pkg::DTM_MSPLT: t0l_r <= t0l_r + 8'h01;
            endcase
         end
         if (wr && i_sfr.addr == dtm_pkg::ADR_T0H) begin
            t0h_r <= i_sfr.wdata;
         end else if (m0.mode == dtm_pkg::DTM_MSPLT) begin
            if (inc0h) t0h_r <= t0h_r + 8'h01;
         end else if (inc0 && m0.mode != dtm_pkg::DTM_MRLD) begin
            // reload mode leaves the high byte untouched
            if (m0.mode == dtm_pkg::DTM_M13 && t0l_r[4:0] == 5'h1f) t0h_r <= t0h_r + 8'h01;
            if (m0.mode == dtm_pkg::DTM_M16 && t0l_r == 8'hff) t0h_r <= t0h_r + 8'h01;
         end
      end
   end

   // timer 1 counting; split mode is excluded through inc1
   always_ff @(posedge i_clk or posedge i_reset) begin
      if (i_reset) begin
         t1l_r <= dtm_pkg::RST_BYTE;
         t1h_r <= dtm_pkg::RST_BYTE;
      end else begin
         if (wr && i_sfr.addr == dtm_pkg::ADR_T1L) begin
            t1l_r <= i_sfr.wdata;
         end else if (inc1) begin
            unique case (m1.mode)
               dtm_pkg::DTM_M13: t1l_r <= {3'h0, t1l_r[4:0] + 5'h01};
               dtm_pkg::DTM_MRLD: t1l_r <= (t1l_r == 8'hff) ? t1h_r : t1l_r + 8'h01;
               default: t1l_r <= t1l_r + 8'h01;
            endcase
         end
         if (wr && i_sfr.addr == dtm_pkg::ADR_T1H) begin
            t1h_r <= i_sfr.wdata;
         end else if (inc1) begin
            if (m1.mode == dtm_pkg::DTM_M13 && t1l_r[4:0] == 5'h1f) t1h_r <= t1h_r + 8'h01;
            if (m1.mode == dtm_pkg::DTM_M16 && t1l_r == 8'hff) t1h_r <= t1h_r + 8'h01;
         end
      end
   end

   // overflow events: count leaves all ones, by wrap or by reload
   assign ovf0  = inc0 & (m0.mode == dtm_pkg::DTM_M13 ? (t0h_r == 8'hff && t0l_r[4:0] == 5'h1f)
                : m0.mode == dtm_pkg::DTM_M16 ? ({t0h_r, t0l_r} == 16'hffff) : (t0l_r == 8'hff));
   assign ovf1  = inc1 & (m1.mode == dtm_pkg::DTM_M13 ? (t1h_r == 8'hff && t1l_r[4:0] == 5'h1f)
                : m1.mode == dtm_pkg::DTM_M16 ? ({t1h_r, t1l_r} == 16'hffff) : (t1l_r == 8'hff));
   assign ovf0h = inc0h & (t0h_r == 8'hff);

   // timer control: run bits only change by software, so counts persist
   always_ff @(posedge i_clk or posedge i_reset) begin
      if (i_reset) begin
         timer_control_reg_r <= dtm_pkg::RST_BYTE;
         timer_mode_reg_r <= dtm_pkg::RST_BYTE;
      end else begin
         if (wr && i_sfr.addr == dtm_pkg::ADR_TIMER_MODE_REG) timer_mode_reg_r <= i_sfr.wdata;
         if (wr && i_sfr.addr == dtm_pkg::ADR_TIMER_CONTROL_REG) timer_control_reg_r <= i_sfr.wdata;
         // hardware set wins over a software clear in the same cycle
         if (ovf0) timer_control_reg_r[dtm_pkg::B_TF0] <= 1'b1;
         // in split mode timer 0 high byte owns the timer 1 flag
         if (m0.mode == dtm_pkg::DTM_MSPLT ? ovf0h : ovf1) timer_control_reg_r[dtm_pkg::B_TF1] <= 1'b1;
      end
   end

   assign o_timer0_irq = timer_control_reg_r[dtm_pkg::B_TF0];
   assign o_timer1_irq = timer_control_reg_r[dtm_pkg::B_TF1];

   // timer 2
   assign t2_serial = t2ctl_r[dtm_pkg::B_RCLK] | t2ctl_r[dtm_pkg::B_SERIAL_TX_CLOCK_SELECT];
   assign trig = t2ctl_r[dtm_pkg::B_EXEN] & ~t2_serial
               & fall(pin_d_r[4], i_timer2_trigger_pin);
   logic inc2;
   assign inc2 = t2ctl_r[dtm_pkg::B_TR2]
               & (~t2ctl_r[dtm_pkg::B_TIMER2_COUNT_SELECT] | fall(pin_d_r[3], i_timer2_event_pin));
   assign ovf2 = inc2 & ({t2h_r, t2l_r} == 16'hffff);
   logic capture, reload;
   assign capture = trig & t2ctl_r[dtm_pkg::B_TIMER2_CAPTURE_SELECT];
   assign reload  = (ovf2 & (~t2ctl_r[dtm_pkg::B_TIMER2_CAPTURE_SELECT] | t2_serial))
                  | (trig & ~t2ctl_r[dtm_pkg::B_TIMER2_CAPTURE_SELECT]);

   // timer2 count: reload beats increment, software write beats both
   always_ff @(posedge i_clk or posedge i_reset) begin
      if (i_reset) begin
         t2l_r <= dtm_pkg::RST_BYTE;
         t2h_r <= dtm_pkg::RST_BYTE;
      end else begin
         if (reload) begin
            t2l_r <= t2rll_r;
            t2h_r <= t2rlh_r;
         end else if (inc2) begin
            {t2h_r, t2l_r} <= {t2h_r, t2l_r} + 16'h0001;
         end
         if (wr && i_sfr.addr == dtm_pkg::ADR_T2CNTL) t2l_r <= i_sfr.wdata;
         if (wr && i_sfr.addr == dtm_pkg::ADR_T2CNTH) t2h_r <= i_sfr.wdata;
      end
   end

   // capture/reload pair
   always_ff @(posedge i_clk or posedge i_reset) begin
      if (i_reset) begin
         t2rll_r <= dtm_pkg::RST_BYTE;
         t2rlh_r <= dtm_pkg::RST_BYTE;
      end else begin
         if (capture) begin
            t2rll_r <= t2l_r;
            t2rlh_r <= t2h_r;
         end
         if (wr && i_sfr.addr == dtm_pkg::ADR_T2RLL) t2rll_r <= i_sfr.wdata;
         if (wr && i_sfr.addr == dtm_pkg::ADR_T2RLH) t2rlh_r <= i_sfr.wdata;
      end
   end

   // timer2 control with sticky flags; set wins over clear
   always_ff @(posedge i_clk or posedge i_reset) begin
      if (i_reset) begin
         t2ctl_r <= dtm_pkg::RST_BYTE;
      end else begin
         if (wr && i_sfr.addr == dtm_pkg::ADR_T2CTL) t2ctl_r <= i_sfr.wdata;
         if (ovf2 && !t2_serial) t2ctl_r[dtm_pkg::B_TF2] <= 1'b1;
         if (trig) t2ctl_r[dtm_pkg::B_TIMER2_EXTERNAL_FLAG] <= 1'b1;
      end
   end

   assign o_timer2_irq = t2ctl_r[dtm_pkg::B_TF2] | t2ctl_r[dtm_pkg::B_TIMER2_EXTERNAL_FLAG];

   // serial clock pulses, registered; timer 1 overflow even while timer 0 split
   always_ff @(posedge i_clk or posedge i_reset) begin
      if (i_reset) begin
         o_serial_rx_clk <= 1'b0;
         o_serial_tx_clk <= 1'b0;
      end else begin
         o_serial_rx_clk <= t2ctl_r[dtm_pkg::B_RCLK] ? ovf2 : ovf1;
         o_serial_tx_clk <= t2ctl_r[dtm_pkg::B_SERIAL_TX_CLOCK_SELECT] ? ovf2 : ovf1;
      end
   end

   // read mux; unmapped addresses read zero
   always_comb begin
      unique case (i_sfr.addr)
         dtm_pkg::ADR_TIMER_CONTROL_REG:   o_rdata = timer_control_reg_r;
         dtm_pkg::ADR_TIMER_MODE_REG:   o_rdata = timer_mode_reg_r;
         dtm_pkg::ADR_T0L:    o_rdata = t0l_r;
         dtm_pkg::ADR_T0H:    o_rdata = t0h_r;
         dtm_pkg::ADR_T1L:    o_rdata = t1l_r;
         dtm_pkg::ADR_T1H:    o_rdata = t1h_r;
         dtm_pkg::ADR_T2CTL:  o_rdata = t2ctl_r;
         dtm_pkg::ADR_T2RLL:  o_rdata = t2rll_r;
         dtm_pkg::ADR_T2RLH:  o_rdata = t2rlh_r;
         dtm_pkg::ADR_T2CNTL: o_rdata = t2l_r;
         dtm_pkg::ADR_T2CNTH: o_rdata = t2h_r;
         default:             o_rdata = 8'h00;
      endcase
   end
endmodule

// *** verilog/dtm_pkg.sv ***
// Purpose: constants and types for the dual timer / timer2 control block
// Assumes: sfr bus of the core, 8-bit data, one core clock
// Notes:   mode encodings follow the mode register layout
//
// Functional notes
// - mode 1 runs timer 0/1 as a full 16-bit counter.
// - mode 2 counts low byte; overflow sets flag, reloads low from high.
// - timer 1 in mode 3 holds its count as if run were cleared.
// - mode 3 timer 0 low byte is an 8-bit counter with timer 0 controls.
// - mode 3 timer 0 high byte counts cycles, uses timer 1 run and flag.
// - timer 1 stops/starts via own mode 3; its overflow still feeds serial baud.
// - timer2 overflow flag sets on overflow unless a serial clock select is set.
// - timer2 external flag sets on enabled trigger falling edge capture or reload.
// - bit 5 selects timer2 overflow as serial receive clock, else timer 1.
// - bit 4 selects timer2 overflow as serial transmit clock, else timer 1.
// - bit 3 enables trigger pin falling edges when timer2 not serial clock.
// - bit 2 runs timer2, clear halts it.
// - bit 1 counts event pin edges, clear counts core clocks.
// - bit 0 capture on trigger edge, clear reload on overflow and trigger.
// - any serial clock select forces reload on overflow, ignoring capture select.
// - timer2 has count and capture/reload byte pairs, all software read/write.
// - timer 0/1 advance when run set and gate clear or irq input high.
// - overflow flag sets when count leaves all ones, by wrap to zero or by reload.
// - setting run does not clear counts; counting resumes.
package dtm_pkg;
   localparam logic [7:0] ADR_TIMER_CONTROL_REG   = 8'h88;
   localparam logic [7:0] ADR_TIMER_MODE_REG   = 8'h89;
   localparam logic [7:0] ADR_T0L    = 8'h8a;
   localparam logic [7:0] ADR_T1L    = 8'h8b;
   localparam logic [7:0] ADR_T0H    = 8'h8c;
   localparam logic [7:0] ADR_T1H    = 8'h8d;
   localparam logic [7:0] ADR_T2CTL  = 8'hc8;
   localparam logic [7:0] ADR_T2RLL  = 8'hca;
   localparam logic [7:0] ADR_T2RLH  = 8'hcb;
   localparam logic [7:0] ADR_T2CNTL = 8'hcc;
   localparam logic [7:0] ADR_T2CNTH = 8'hcd;
   // timer2_control bit positions
   localparam int B_TF2 = 7;
   localparam int B_TIMER2_EXTERNAL_FLAG = 6;
   localparam int B_RCLK = 5;
   localparam int B_SERIAL_TX_CLOCK_SELECT = 4;
   localparam int B_EXEN = 3;
   localparam int B_TR2 = 2;
   localparam int B_TIMER2_COUNT_SELECT = 1;
   localparam int B_TIMER2_CAPTURE_SELECT = 0;
   // timer_control_reg bit positions (upper nibble)
   localparam int B_TF1 = 7;
   localparam int B_TR1 = 6;
   localparam int B_TF0 = 5;
   localparam int B_TR0 = 4;
   localparam logic [7:0] RST_BYTE = 8'h00;
   typedef enum logic [1:0] {
      DTM_M13   = 2'b00,
      DTM_M16   = 2'b01,
      DTM_MRLD  = 2'b10,
      DTM_MSPLT = 2'b11
   } dtm_mode_e;
   // per-timer field of the mode register
   typedef struct packed {
      logic      gate;
      logic      ct;
      dtm_mode_e mode;
   } dtm_tmode_s;
   // sfr bus request
   typedef struct packed {
      logic       wr;
      logic [7:0] addr;
      logic [7:0] wdata;
   } dtm_sfr_s;
endpackage

// *** verification/dtm_checker.sv ***
// Purpose: port-level checks for the timer block
// Assumes: single clock, async high reset
// Notes:   register state is only seen while it is addressed
module dtm_checker (
   input  wire logic         i_clk,
   input  wire logic         i_reset,
   input  dtm_pkg::dtm_sfr_s i_sfr,
   input  wire logic [7:0]   o_rdata,
   input  wire logic         o_timer0_irq,
   input  wire logic         o_timer1_irq,
   input  wire logic         o_timer2_irq,
   input  wire logic         o_serial_rx_clk,
   input  wire logic         o_serial_tx_clk
);
   logic c8;
   // control register shown and not being rewritten, so flags read true
   assign c8 = i_sfr.addr == 8'hc8 && !i_sfr.wr;
   default clocking @(posedge i_clk); endclocking
   default disable iff (i_reset);
   t2_irq_mirror_a: assert property (i_sfr.addr == 8'hc8 |-> o_timer2_irq == (o_rdata[7] | o_rdata[6]))
      else $error("timer2 irq differs from its flags");
   flag_irq_mirror_a: assert property (i_sfr.addr == 8'h88 |-> o_timer0_irq == o_rdata[5] && o_timer1_irq == o_rdata[7])
      else $error("timer irq differs from overflow flag");
   tf2_blocked_a: assert property (c8 && |o_rdata[5:4] && !o_rdata[7] |=> !(c8 && o_rdata[7]))
      else $error("timer2 overflow flag set while serial clock selected");
   timer2_external_flag_blocked_a: assert property (c8 && (!o_rdata[3] || |o_rdata[5:4]) && !o_rdata[6] |=> !(c8 && o_rdata[6]))
      else $error("external flag set while trigger disabled");
   rx_quiet_a: assert property ((c8 && o_rdata[5] && !o_rdata[2]) [*3] |-> !o_serial_rx_clk)
      else $error("receive clock pulse with stopped timer2 selected");
   tx_quiet_a: assert property ((c8 && o_rdata[4] && !o_rdata[2]) [*3] |-> !o_serial_tx_clk)
      else $error("transmit clock pulse with stopped timer2 selected");
   data_wr_a: assert property (i_sfr.wr && i_sfr.addr inside {8'hca, 8'hcb, 8'hcc, 8'hcd}
      ##1 i_sfr.addr == $past(i_sfr.addr) |-> o_rdata == $past(i_sfr.wdata))
      else $error("timer2 data byte did not take the write");
   ctl_wr_a: assert property (i_sfr.wr && i_sfr.addr == 8'hc8 ##1 i_sfr.addr == 8'hc8
      |-> o_rdata[5:0] == $past(i_sfr.wdata[5:0]))
      else $error("timer2 control bits did not take the write");
   // main scenarios reached
   cover property (o_serial_rx_clk && o_serial_tx_clk);
   cover property (c8 && o_rdata[6]);
   cover property (o_timer1_irq && i_sfr.addr == 8'h88);
endmodule

bind dtm_timers dtm_checker chk (.i_clk, .i_reset, .i_sfr, .o_rdata, .o_timer0_irq,
   .o_timer1_irq, .o_timer2_irq, .o_serial_rx_clk, .o_serial_tx_clk);

// *** verification/dtm_core_model.sv ***
// Purpose: core side of the sfr bus, one access per cycle
// Assumes: read data is combinational from the address
// Notes:   a write stays up until the next access replaces it
module dtm_core_model (
   input  wire logic         i_clk,
   input  wire logic [7:0]   i_rdata,
   output dtm_pkg::dtm_sfr_s o_sfr
);
   timeunit 1ns;
   timeprecision 100ps;
   initial o_sfr = '0;
   // change just after the edge, hold through the taking edge
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge i_clk) #1 o_sfr = {1'b1, a, d};
   endtask
   // read sampled late in the cycle once the mux has settled
   task automatic rd(input logic [7:0] a, output logic [7:0] v);
      @(posedge i_clk) #1 o_sfr = {1'b0, a, 8'h00};
      #7 v = i_rdata;
   endtask
endmodule

// *** verification/test_dual_timer_modes_and_timer2_control.sv ***
// Purpose: self-checking bench for the timer block
// Assumes: core model drives the sfr bus, bench drives the pins
// Notes:   op table is kind, irq/pulse mask, address, data
module test_dual_timer_modes_and_timer2_control;
   timeunit 1ns;
   timeprecision 100ps;
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin failures++; \
   $display("ERROR %s expected %h seen %h", n, e, g); end end
   logic              clk, rst, t0, t1, t2, rx, tx;
   logic [2:0]        pins, ev;
   logic [7:0]        rdata, v, a, d;
   logic [3:0]        k, ie;
   dtm_pkg::dtm_sfr_s sfr;
   int                seed = 5, failures = 0, samples_checked = 0, rx_n, tx_n;
   // kinds: 0 write, 1 read, 2 read with irqs, 3 set pins, 4 count serial pulses
   logic [23:0]       ops[$] = {24'h10c800, 24'h10cc00, 24'h10c900, 24'h00c9ff, 24'h10c900,
      24'h00ca34, 24'h00cb12, 24'h00ccfe, 24'h00cdff, 24'h00c804, 24'h10ccfe, 24'h10cdff,
      24'h21cc34, 24'h10c884, 24'h00c800, 24'h20cc37, 24'h10cc37, 24'h10c800,
      24'h00caf0, 24'h00cbff, 24'h00ccf0, 24'h00cdff, 24'h00c835, 24'h10c835, 24'h43cd28,
      24'h10cdff, 24'h10c835, 24'h00c800,
      24'h008901, 24'h008afe, 24'h008cff, 24'h008810, 24'h108afe, 24'h108cff, 24'h248830,
      24'h008800, 24'h008909, 24'h008a00, 24'h008810, 24'h108a00, 24'h108a00, 24'h300005,
      24'h108a01, 24'h108a02, 24'h008800, 24'h300004,
      24'h008933, 24'h008b55, 24'h008cfe, 24'h008840, 24'h108cfe, 24'h108840, 24'h2288c0,
      24'h108b55, 24'h008923, 24'h008dff, 24'h008bff, 24'h438814, 24'h108dff,
      24'h00c830, 24'h40c814, 24'h00c800, 24'h00ca00, 24'h00cc78, 24'h00cd56, 24'h00c801,
      24'h300000, 24'h300004, 24'h10ca00, 24'h10c801,
      24'h00c809, 24'h300000, 24'h300004, 24'h23c849, 24'h10ca78, 24'h10cb56,
      24'h00c808, 24'h00cc00, 24'h00cd00, 24'h300000, 24'h300004, 24'h10cc78, 24'h10cd56,
      24'h10c848};

   dtm_core_model core (.i_clk(clk), .i_rdata(rdata), .o_sfr(sfr));
   dtm_timers dut (.i_clk(clk), .i_reset(rst), .i_sfr(sfr), .o_rdata(rdata),
      .i_ext_irq0_input(pins[0]), .i_ext_irq1_input(pins[1]), .i_timer0_event_pin(ev[0]),
      .i_timer1_event_pin(ev[1]), .i_timer2_event_pin(ev[2]), .i_timer2_trigger_pin(pins[2]),
      .o_timer0_irq(t0), .o_timer1_irq(t1), .o_timer2_irq(t2), .o_serial_rx_clk(rx),
      .o_serial_tx_clk(tx));

   // 100 MHz core clock
   initial begin
      clk = 0;
      forever #5 clk = ~clk;
   end
   // random event pins keep the counter inputs busy without being selected
   always @(posedge clk) begin
      #1 ev = 3'($random(seed));
   end
   // serial pulses last one cycle; sampled mid-cycle, away from the edge that launches them
   always @(negedge clk) begin
      rx_n += int'(rx);
      tx_n += int'(tx);
   end

   task automatic final_report();
      $display("checks %0d failures %0d", samples_checked, failures);
      if (failures == 0 && samples_checked > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask

   // a hang costs one failure and still gives a verdict
   initial begin
      #20000;
      failures++;
      final_report();
   end

   // table walk, then random byte writes of the timer2 data registers
   initial begin
      rst = 1;
      pins = 3'h4;
      ev = 3'h0;
      rx_n = 0;
      tx_n = 0;
      repeat (4) @(posedge clk);
      #1 rst = 0;
      foreach (ops[n]) begin
         {k, ie, a, d} = ops[n];
         case (k)
            4'h0: core.wr(a, d);
            4'h1, 4'h2: begin
               core.rd(a, v);
               `CHK("read data", d, v)
               if (k == 4'h2) `CHK("irq lines", ie[2:0], {t0, t1, t2})
            end
            4'h3: begin
               core.rd(8'h00, v);
               @(posedge clk) #1 pins = d[2:0];
            end
            default: begin
               repeat (2) core.rd(a, v);
               rx_n = 0;
               tx_n = 0;
               repeat (d) core.rd(a, v);
               `CHK("serial pulses", ie[1:0], {rx_n != 0, tx_n != 0})
            end
         endcase
      end
      repeat (8) begin
         a = 8'hca + 8'($random(seed) & 3);
         d = 8'($random(seed));
         core.wr(a, d);
         core.rd(a, v);
         `CHK("random byte", d, v)
      end
      final_report();
   end
endmodule
